// file: core/sbs_pkg.sv
// package: register map, field layout and bus types for the slip status block
package sbs_pkg;
   localparam int unsigned ADDR_W     = 14;
   // register indices; one word each, so the bus byte address is four times the index
   localparam logic [11:0] IDX_STATUS = 12'hb08;   // slip_event_status
   localparam logic [11:0] IDX_ENABLE = 12'hb09;   // slip_event_enable
   localparam logic [11:0] IDX_CTRL   = 12'hb10;   // framer control
   localparam logic [11:0] IDX_RAW    = 12'hb14;   // current error run
   localparam logic [ADDR_W-1:0] OFF_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] OFF_ENABLE = {IDX_ENABLE, 2'b00};
   localparam logic [ADDR_W-1:0] OFF_CTRL   = {IDX_CTRL, 2'b00};
   localparam logic [ADDR_W-1:0] OFF_RAW    = {IDX_RAW, 2'b00};
   // status bit positions
   localparam int unsigned B_TX_OVF   = 7;
   localparam int unsigned B_TX_UNF   = 6;
   localparam int unsigned B_TX_SLIP  = 5;
   localparam int unsigned B_CAS_LOCK = 4;
   localparam int unsigned B_CRC_LOCK = 3;
   localparam int unsigned B_RX_OVF   = 2;
   localparam int unsigned B_RX_UNF   = 1;
   localparam int unsigned B_RX_SLIP  = 0;
   localparam logic [7:0]  STICKY_MASK = 8'he7;
   localparam logic [7:0]  ENABLE_RST  = 8'h00;
   // control register fields
   localparam int unsigned C_CAS_EN    = 0;
   localparam int unsigned C_CRC_EN    = 1;
   localparam int unsigned C_CNT_LSB   = 4;
   localparam int unsigned CNT_W       = 4;
   localparam logic [3:0]  CNT_RST     = 4'h3;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic wr;   // write side strobe
      logic rd;   // read side strobe
   } sbs_port_t;

   typedef struct packed {
      logic overflow;
      logic underflow;
   } sbs_evt_t;
endpackage : sbs_pkg

// file: core/sbs_slip_mon.sv
// slip buffer fill tracker: detects full-write and empty-read frame slips
`timescale 1ns/1ps
module sbs_slip_mon
   import sbs_pkg::*;
#(
   parameter int unsigned DEPTH = 64   // two frames of 32 octets
) (
   input  wire logic      clock,
   input  wire logic      sys_rst,
   input  wire sbs_port_t port,
   output sbs_evt_t       evt
);
   localparam int unsigned LW    = $clog2(DEPTH + 1);
   localparam logic [LW-1:0] FULL  = LW'(DEPTH);
   localparam logic [LW-1:0] FRAME = LW'(DEPTH / 2);

   typedef struct packed {
      logic [LW-1:0] level;
      sbs_evt_t      evt;
   } sbs_mon_t;

   sbs_mon_t s_q;
   sbs_mon_t s_d;

   // full write deletes a frame, empty read repeats one
   always_comb begin
      s_d = s_q;
      s_d.evt = '0;
      if (port.wr && !port.rd) begin
         if (s_q.level == FULL) begin
            s_d.level = FULL - FRAME + LW'(1);   // deleted frame, then the write
            s_d.evt.overflow = 1'b1;
         end else begin
            s_d.level = s_q.level + LW'(1);
         end
      end else if (port.rd && !port.wr) begin
         if (s_q.level == '0) begin
            s_d.level = FRAME - LW'(1);          // repeated frame, less this read
            s_d.evt.underflow = 1'b1;
         end else begin
            s_d.level = s_q.level - LW'(1);
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign evt = s_q.evt;
endmodule : sbs_slip_mon

// file: core/sbs_status.sv
// slip event status, lock indications and interrupt over AXI4-Lite
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - tx full write deletes frame, sets bit7
// - tx empty read repeats frame, sets bit6
// - any tx slip sets bit5
// - event flags sticky, clear on read, reset 0
// - bit4 shows cas multiframe lock
// - cas lock lost after programmed error count
// - cas lock meaningless with signalling disabled
// - bit3 shows crc multiframe lock
// - crc lock meaningless with crc disabled
// - rx full write deletes frame, sets bit2
// - bit1 sticky rx underflow
// - rx slip on either direction sets bit0
// - enable bit 1 lets flag interrupt
module sbs_status
   import sbs_pkg::*;
#(
   parameter int unsigned DEPTH = 64
) (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   // slip buffer strobes
   input  wire logic              tx_wr,
   input  wire logic              tx_rd,
   input  wire logic              rx_wr,
   input  wire logic              rx_rd,
   // receive framer indications, from pins
   input  wire logic              cas_mfa_ok,
   input  wire logic              cas_mfa_err,
   input  wire logic              crc_lock_in,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   irq
);
   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic              aw_have;
      logic [31:0]       wdata;
      logic              wstb0;        // byte 0 strobe of a held write
      logic              w_have;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [7:0]        flags;        // sticky bits of status
      logic [7:0]        enable;       // slip_event_enable
      logic              cas_en;
      logic              crc_en;
      logic [CNT_W-1:0]  signalling_loss_error_count;
      logic [CNT_W-1:0]  err_run;
      logic              cas_lock;
      logic              err_held;     // last agreed level of the error pin
      logic [2:0]        sy_ok;        // three-stage pin samplers
      logic [2:0]        sy_err;
      logic [2:0]        sy_crc;
      logic              crc_lock;
      logic              irq;
   } sbs_state_t;

   sbs_state_t s_q;
   sbs_state_t s_d;
   sbs_evt_t   tx_evt;
   sbs_evt_t   rx_evt;

   // agreed level once stages two and three match, else hold
   function automatic logic agreed(input logic [2:0] sy, input logic held);
      agreed = (sy[1] == sy[2]) ? sy[2] : held;
   endfunction : agreed

   sbs_port_t tx_port;
   sbs_port_t rx_port;

   // strobe pairs bundled per direction for the trackers
   assign tx_port = '{wr: tx_wr, rd: tx_rd};
   assign rx_port = '{wr: rx_wr, rd: rx_rd};

   // one tracker per direction
   sbs_slip_mon #(.DEPTH(DEPTH)) u_tx (
      .clock   (clock),
      .sys_rst (sys_rst),
      .port    (tx_port),
      .evt     (tx_evt)
   );
   sbs_slip_mon #(.DEPTH(DEPTH)) u_rx (
      .clock   (clock),
      .sys_rst (sys_rst),
      .port    (rx_port),
      .evt     (rx_evt)
   );

   logic [7:0]  status_view;
   logic [7:0]  set_vec;
   logic        rd_go;
   logic        wr_go;
   logic [ADDR_W-1:0] waddr;
   logic [31:0] wdat;
   logic        wstb;
   logic [CNT_W:0] run_next;      // one bit wider so a full count cannot wrap
   logic        ok_lvl;
   logic        err_lvl;
   logic        err_rise;

   always_comb begin
      s_d = s_q;
      // pin samplers: first stage feeds only the second
      s_d.sy_ok  = {s_q.sy_ok[1:0], cas_mfa_ok};
      s_d.sy_err = {s_q.sy_err[1:0], cas_mfa_err};
      s_d.sy_crc = {s_q.sy_crc[1:0], crc_lock_in};
      // levels count only once stages two and three agree
      ok_lvl   = agreed(s_q.sy_ok, 1'b0);
      err_lvl  = agreed(s_q.sy_err, s_q.err_held);
      // held level resets low like the idle pin, so no false edge after reset
      err_rise = err_lvl && !s_q.err_held;
      s_d.err_held = err_lvl;
      run_next = {1'b0, s_q.err_run} + (CNT_W+1)'(1);
      if (ok_lvl) begin
         s_d.err_run = '0;
         s_d.cas_lock = 1'b1;
      end else if (err_rise) begin
         // one more bad word: lock is lost once the run reaches the count
         if (run_next >= {1'b0, s_q.signalling_loss_error_count}) begin
            s_d.cas_lock = 1'b0;
            s_d.err_run  = s_q.signalling_loss_error_count;
         end else begin
            s_d.err_run = run_next[CNT_W-1:0];
         end
      end
      // lock held low while signalling disabled
      if (!s_q.cas_en) begin
         s_d.cas_lock = 1'b0;
         s_d.err_run  = '0;
      end
      // crc lock follows framer, gated by enable
      s_d.crc_lock = s_q.crc_en & agreed(s_q.sy_crc, s_q.crc_lock);

      set_vec = '0;
      set_vec[B_TX_OVF]  = tx_evt.overflow;
      set_vec[B_TX_UNF]  = tx_evt.underflow;
      set_vec[B_TX_SLIP] = tx_evt.overflow | tx_evt.underflow;
      set_vec[B_RX_OVF]  = rx_evt.overflow;
      set_vec[B_RX_UNF]  = rx_evt.underflow;
      set_vec[B_RX_SLIP] = rx_evt.overflow | rx_evt.underflow;

      status_view = (s_q.flags & STICKY_MASK);
      status_view[B_CAS_LOCK] = s_q.cas_lock;
      status_view[B_CRC_LOCK] = s_q.crc_lock;

      // axi write: hold address and data until both arrive
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata  = s_axi_wdata;
         s_d.wstb0  = s_axi_wstrb[0];
      end
      // the strobe is kept with the data: the master may drop it before the address
      waddr = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : s_q.awaddr;
      wdat  = s_axi_wvalid && s_axi_wready ? s_axi_wdata : s_q.wdata;
      wstb  = s_axi_wvalid && s_axi_wready ? s_axi_wstrb[0] : s_q.wstb0;
      wr_go = (s_q.aw_have | (s_axi_awvalid & s_axi_awready))
              & (s_q.w_have | (s_axi_wvalid & s_axi_wready)) & !s_q.bvalid;
      if (wr_go) begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = RESP_OKAY;
         case (waddr)
            OFF_ENABLE: begin
               if (wstb) begin
                  s_d.enable = wdat[7:0] & STICKY_MASK;
               end
            end
            OFF_CTRL: begin
               if (wstb) begin
                  s_d.cas_en = wdat[C_CAS_EN];
                  s_d.crc_en = wdat[C_CRC_EN];
                  s_d.signalling_loss_error_count = wdat[C_CNT_LSB +: CNT_W];
               end
            end
            OFF_STATUS: ;   // read-only, write ignored
            default: s_d.bresp = RESP_SLVERR;
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      // axi read: answer one cycle after the address
      rd_go = s_axi_arvalid && s_axi_arready;
      s_d.flags = s_q.flags;
      if (rd_go) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = RESP_OKAY;
         s_d.rdata  = '0;
         case (s_axi_araddr)
            OFF_STATUS: begin
               s_d.rdata[7:0] = status_view;
               s_d.flags = '0;
            end
            OFF_ENABLE: s_d.rdata[7:0] = s_q.enable;
            OFF_CTRL: begin
               s_d.rdata[C_CAS_EN] = s_q.cas_en;
               s_d.rdata[C_CRC_EN] = s_q.crc_en;
               s_d.rdata[C_CNT_LSB +: CNT_W] = s_q.signalling_loss_error_count;
            end
            OFF_RAW: s_d.rdata[CNT_W-1:0] = s_q.err_run;
            default: s_d.rresp = RESP_SLVERR;
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      // a same-cycle event survives the clearing read
      s_d.flags = (s_d.flags | set_vec) & STICKY_MASK;
      // only enabled flags raise the interrupt
      s_d.irq = |(s_d.flags & s_d.enable);
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.signalling_loss_error_count <= CNT_RST;
         s_q.enable <= ENABLE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ready terms are state only; each channel has one slot
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_awready <= !s_d.aw_have && !s_d.bvalid;
         s_axi_wready  <= !s_d.w_have && !s_d.bvalid;
         s_axi_arready <= !s_d.rvalid;
      end
   end

   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp  = s_q.bresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata  = s_q.rdata;
   assign s_axi_rresp  = s_q.rresp;
   assign irq          = s_q.irq;
endmodule : sbs_status

// file: tb/sbs_status_sva.sv
// checker: bus handshake, response codes, clear-on-read and interrupt cause
`timescale 1ns/1ps
module sbs_status_sva
   import sbs_pkg::*;
#(
   parameter int unsigned DEPTH = 64
) (
   input wire logic              clock,
   input wire logic              sys_rst,
   input wire logic              tx_wr,
   input wire logic              tx_rd,
   input wire logic              rx_wr,
   input wire logic              rx_rd,
   input wire logic              s_axi_awready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              irq
);
   logic       any_s;
   logic [3:0] sq_q;
   logic       dirty_q;
   logic       rd_dirty_q;
   logic       rd_st_q;
   logic       rd_map_q;
   assign any_s = tx_wr | tx_rd | rx_wr | rx_rd;
   // quiet time since a strobe or a write answer; flags lag strobes, so stay wide
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sq_q <= 4'hf;
         dirty_q <= 1'b0;
         rd_dirty_q <= 1'b0;
         rd_st_q <= 1'b0;
         rd_map_q <= 1'b0;
      end else begin
         if (any_s || s_axi_bvalid)
            sq_q <= 4'h0;
         else if (sq_q != 4'hf)
            sq_q <= sq_q + 4'h1;
         if (any_s)
            dirty_q <= 1'b1;
         if (s_axi_arvalid && s_axi_arready) begin
            rd_dirty_q <= dirty_q | any_s;
            rd_st_q <= (s_axi_araddr == OFF_STATUS);
            rd_map_q <= s_axi_araddr inside {OFF_STATUS, OFF_ENABLE, OFF_CTRL, OFF_RAW};
            if (s_axi_araddr == OFF_STATUS && !any_s)
               dirty_q <= (sq_q < 4'h4);
         end
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   bvalid_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped early");
   rvalid_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   read_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while one pends");
   write_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while one pends");
   read_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp == (rd_map_q ? RESP_OKAY
      : RESP_SLVERR)) else $error("wrong read response code");
   read_clears_a: assert property (s_axi_rvalid && rd_st_q && !rd_dirty_q
      |-> (s_axi_rdata[7:0] & STICKY_MASK) == 8'h00) else $error("flag not cleared");
   // an enable write may unmask an old flag: its answer shows in the same cycle
   irq_cause_a: assert property ($rose(irq) |-> sq_q < 4'h6 || s_axi_bvalid)
      else $error("interrupt without cause");
endmodule : sbs_status_sva

// file: tb/tb.sv
// testbench: slip status block through its register bus
`timescale 1ns/1ps
module tb;
   import sbs_pkg::*;
   localparam int D = 4;   // short buffer keeps slip runs brief
   logic              clock = 1'b0;
   logic              sys_rst = 1'b1;
   logic [4:0]        stb = 5'h00;   // tx wr, tx rd, rx wr, rx rd, cas error
   logic              cas_ok = 1'b0;
   logic              crc_in = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic [ADDR_W-1:0] araddr = '0;
   logic [31:0]       wdata = 32'h0;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]        bresp, rresp, rs;
   logic [31:0]       rdata, rd;
   int                mismatches = 0, n_tests = 0, cyc = 0;
   sbs_status #(.DEPTH(D)) sbs_status_i (
      .clock(clock), .sys_rst(sys_rst), .tx_wr(stb[0]), .tx_rd(stb[1]),
      .rx_wr(stb[2]), .rx_rd(stb[3]), .cas_mfa_ok(cas_ok), .cas_mfa_err(stb[4]),
      .crc_lock_in(crc_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
   always #5 clock = ~clock;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   // handshakes judged at the falling edge, where the slave's outputs are settled
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
      logic ta, tw, tk;
      @(posedge clock);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clock);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tk = bvalid;
         r = bresp;
         @(posedge clock);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end while (!tk);
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tk;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clock);
         ta = arvalid & arready;
         tk = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clock);
         if (ta)
            arvalid <= 1'b0;
      end while (!tk);
      rready <= 1'b0;
   endtask : axi_rd
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
      axi_rd(a, rd, rs);
      check({24'h0, rd[7:0] & m}, {24'h0, e});
   endtask : rd_chk
   // n pulses w cycles high, w low; trailing wait covers the synchroniser
   task automatic pulse(input int i, input int n, input int w);
      @(posedge clock);
      repeat (n) begin
         stb[i] <= 1'b1;
         repeat (w) @(posedge clock);
         stb[i] <= 1'b0;
         repeat (w) @(posedge clock);
      end
      repeat (6) @(negedge clock);
   endtask : pulse
   // hang guard, far beyond the few hundred cycles the run needs
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches = mismatches + 1;
         final_report();
      end
   end
   initial begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      rd_chk(OFF_STATUS, 8'hff, 8'h00);
      rd_chk(OFF_CTRL, 8'hf0, 8'h30);
      axi_rd(14'h2c80, rd, rs);
      check({30'h0, rs}, {30'h0, RESP_SLVERR});
      axi_wr(OFF_ENABLE, 8'hff, rs);
      rd_chk(OFF_ENABLE, 8'hff, 8'he7);
      axi_wr(OFF_ENABLE, 8'h40, rs);
      // tx underflow: only its empty flag is unmasked
      pulse(1, 1, 1);
      check({31'h0, irq}, 32'h1);
      rd_chk(OFF_STATUS, 8'he7, 8'h60);
      repeat (3) @(negedge clock);
      check({31'h0, irq}, 32'h0);
      rd_chk(OFF_STATUS, 8'he7, 8'h00);
      // tx overflow from level D/2-1; masked, and a status write changes nothing
      pulse(0, D / 2 + 2, 1);
      check({31'h0, irq}, 32'h0);
      axi_wr(OFF_STATUS, 8'hff, rs);
      check({30'h0, rs}, {30'h0, RESP_OKAY});
      rd_chk(OFF_STATUS, 8'he7, 8'ha0);
      pulse(3, 1, 1);
      rd_chk(OFF_STATUS, 8'he7, 8'h03);
      pulse(2, D / 2 + 2, 1);
      rd_chk(OFF_STATUS, 8'he7, 8'h05);
      // lock indications: hidden while disabled, then crc lost with its pin and cas after three bad words
      crc_in <= 1'b1;
      cas_ok <= 1'b1;
      repeat (8) @(posedge clock);
      rd_chk(OFF_STATUS, 8'h18, 8'h00);
      axi_wr(OFF_CTRL, 8'h33, rs);
      repeat (8) @(posedge clock);
      rd_chk(OFF_STATUS, 8'h18, 8'h18);
      cas_ok <= 1'b0;
      crc_in <= 1'b0;
      pulse(4, 2, 4);
      rd_chk(OFF_STATUS, 8'h18, 8'h10);
      rd_chk(OFF_RAW, 8'h0f, 8'h02);
      pulse(4, 1, 4);
      rd_chk(OFF_STATUS, 8'h10, 8'h00);
      // tx level D/2+1 drained, one read more underflows; then a mid-run reset
      pulse(1, D, 1);
      check({31'h0, irq}, 32'h1);
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      @(negedge clock);
      check({31'h0, irq}, 32'h0);
      rd_chk(OFF_STATUS, 8'hff, 8'h00);
      rd_chk(OFF_ENABLE, 8'hff, ENABLE_RST);
      rd_chk(OFF_CTRL, 8'hf3, 8'h30);
      final_report();
   end
endmodule : tb
bind sbs_status sbs_status_sva #(.DEPTH(DEPTH)) sbs_status_sva_i (
   .clock(clock), .sys_rst(sys_rst), .tx_wr(tx_wr), .tx_rd(tx_rd), .rx_wr(rx_wr),
   .rx_rd(rx_rd), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .irq(irq));
